/* verilog/ntfsf_target_fsm.sv */
`timescale 1ns/10ps
module ntfsf_target_fsm (
  input  wire logic                  clk_sys,    // 40 MHz clock
  input  wire logic                  resetn,     // async reset, low
  input  wire logic                  hsel,       // AHB select
  input  wire logic [31:0]           haddr,      // AHB address
  input  wire logic [1:0]            htrans,     // AHB transfer type
  input  wire logic                  hwrite,     // AHB write
  input  wire logic [2:0]            hsize,      // AHB size
  input  wire logic [31:0]           hwdata,     // AHB write data
  input  wire logic                  hready,     // AHB bus ready
  output logic      [31:0]           hrdata,     // AHB read data
  output logic                       hreadyout,  // AHB slave ready
  output logic                       hresp,      // AHB response
  input  ntfsf_pkg::ntfsf_host_cyc_t hostCyc,    // host cycle
  output ntfsf_pkg::ntfsf_host_rd_t  hostRd,     // host read answer
  output logic                       targetReady,// ready/busy, high ready
  input  ntfsf_pkg::ntfsf_lun_ind_t  lunInd,     // LUN indications
  output ntfsf_pkg::ntfsf_lun_req_t  lunReq      // LUN requests
);

  typedef enum logic [3:0] {
    S_IDLE, S_IDLE_RD, S_SF_EXEC, S_SF_ADDR, S_SF_WAIT, S_SF_STORE,
    S_SF_COMPLETE, S_SF_UPDATE, S_GF_EXEC, S_GF_ADDR, S_GF_RETR,
    S_GF_READY, S_RS_EXEC, S_RS_PERFORM, S_RD_STATUS
  } ntfsf_state_t;

  ntfsf_state_t                 state;
  ntfsf_state_t                 resume;
  logic [7:0]                   lastCmd;
  logic [7:0]                   featAddr;
  logic [ntfsf_pkg::PIDX_W-1:0] pIdx;
  logic [ntfsf_pkg::PIDX_W-1:0] rdIdx;
  logic                         statusOut;
  logic                         chgCol;
  logic                         chgColEnh;
  logic                         enhReq;
  logic [ntfsf_pkg::LUN_W-1:0]  selLun;
  logic                         lunReadyBit;
  logic                         lunDonePend;
  logic                         wrPend;
  logic [7:0]                   wrOff;
  logic [31:0]                  rdMux;
  logic [7:0]                   storeByte;
  logic [ntfsf_pkg::PAR_W-1:0]  storeAll;

  // ****************************************
  // decode of accepted events
  // ****************************************
  wire inIdle   = (state == S_IDLE) || (state == S_IDLE_RD);
  wire busyWait = (state == S_SF_COMPLETE) || (state == S_GF_RETR);
  wire rsCmd    = hostCyc.cmd && hostCyc.value == ntfsf_pkg::CMD_READ_STATUS;
  wire sfStart  = inIdle && hostCyc.cmd && hostCyc.value == ntfsf_pkg::CMD_SET_FEAT;
  wire gfStart  = inIdle && hostCyc.cmd && hostCyc.value == ntfsf_pkg::CMD_GET_FEAT;
  wire addrTake = (state == S_SF_EXEC || state == S_GF_EXEC) && hostCyc.addr;
  wire dataTake = (state == S_SF_WAIT) && hostCyc.dataWr;
  wire sfApply  = (state == S_SF_STORE) && pIdx == ntfsf_pkg::LAST_PIDX;
  wire gfFetch  = (state == S_GF_ADDR);
  wire sfFinish = (state == S_SF_COMPLETE) && lunDonePend;
  wire gfReadyGo = (state == S_GF_RETR) && lunDonePend;
  wire rsGo     = (state == S_RS_EXEC) && !enhReq;
  wire busyRs   = busyWait && !lunDonePend && rsCmd;
  wire rdStatusReq = busyWait && !lunDonePend && !rsCmd && hostCyc.rdReq && statusOut;
  wire idleRead = (state == S_IDLE_RD) && hostCyc.rdReq;

  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE, S_IDLE_RD: begin
          if (sfStart) begin
            state <= S_SF_EXEC;
          end else if (gfStart) begin
            state <= S_GF_EXEC;
          end else if (rsCmd) begin
            state <= S_RS_EXEC;
          end
        end
        S_SF_EXEC: if (hostCyc.addr) state <= S_SF_ADDR;
        S_SF_ADDR: state <= S_SF_WAIT;
        S_SF_WAIT: if (hostCyc.dataWr) state <= S_SF_STORE;
        S_SF_STORE: begin
          state <= sfApply ? S_SF_COMPLETE : S_SF_WAIT;
        end
        S_SF_COMPLETE, S_GF_RETR: begin
          // completion is checked first, then status cycles
          if (sfFinish) begin
            state <= S_SF_UPDATE;
          end else if (gfReadyGo) begin
            state <= S_GF_READY;
          end else if (rsCmd) begin
            state <= S_RS_EXEC;
          end else if (rdStatusReq) begin
            state <= S_RD_STATUS;
          end
        end
        S_SF_UPDATE: state <= statusOut ? S_IDLE_RD : S_IDLE;
        S_GF_EXEC: if (hostCyc.addr) state <= S_GF_ADDR;
        S_GF_ADDR: state <= S_GF_RETR;
        S_GF_READY: state <= S_IDLE_RD;
        // an illegal 70h under the enhanced flag is dropped
        S_RS_EXEC: state <= enhReq ? resume : S_RS_PERFORM;
        S_RS_PERFORM: state <= (resume == S_IDLE) ? S_IDLE_RD : resume;
        S_RD_STATUS: state <= resume;
      endcase
    end
  end

  // where a status command returns to
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      resume <= S_IDLE;
    end else if (inIdle) begin
      resume <= S_IDLE;
    end else if (sfApply) begin
      resume <= S_SF_COMPLETE;
    end else if (gfFetch) begin
      resume <= S_GF_RETR;
    end
  end

  // ****************************************
  // command bookkeeping
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lastCmd <= ntfsf_pkg::LAST_CMD_RST;
    end else if (sfStart) begin
      lastCmd <= ntfsf_pkg::CMD_SET_FEAT;
    end else if (gfStart) begin
      lastCmd <= ntfsf_pkg::CMD_GET_FEAT;
    end
  end

  // feature address and parameter index
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      featAddr <= ntfsf_pkg::FADDR_RST;
      pIdx     <= '0;
    end else begin
      if (addrTake) featAddr <= hostCyc.value;
      if (sfStart) begin
        pIdx <= '0;
      end else if (state == S_SF_STORE) begin
        pIdx <= pIdx + 1'b1;
      end
    end
  end

  // status output flag: a new feature command starts with data output
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      statusOut <= 1'b0;
    end else if (rsGo) begin
      statusOut <= 1'b1;
    end else if (sfStart || gfStart) begin
      statusOut <= 1'b0;
    end
  end

  // LUN answer is held so it is not lost while a status read runs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lunDonePend <= 1'b0;
    end else if (lunInd.done || lunInd.paramsReady) begin
      lunDonePend <= 1'b1;
    end else if (sfApply || gfFetch || sfFinish || gfReadyGo) begin
      lunDonePend <= 1'b0;
    end
  end

  // ready/busy and the tracked copy of the LUN ready bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      targetReady <= 1'b1;
      lunReadyBit <= 1'b1;
    end else if (sfApply || gfFetch) begin
      targetReady <= 1'b0;
      lunReadyBit <= 1'b0;
    end else if (sfFinish || gfReadyGo) begin
      targetReady <= 1'b1;
      lunReadyBit <= 1'b1;
    end
  end

  // ****************************************
  // LUN request pulses and registered request fields
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lunReq <= '0;
    end else begin
      lunReq.invalidateAll   <= sfStart || gfStart;
      lunReq.srBitClear      <= sfApply || gfFetch;
      lunReq.featureApply    <= sfApply;
      lunReq.featureRetrieve <= gfFetch;
      lunReq.srBitSet        <= sfFinish || gfReadyGo;
      lunReq.status70h       <= rsGo;
      lunReq.lun             <= selLun;
      lunReq.featAddr        <= featAddr;
      lunReq.params          <= storeAll;
    end
  end

  ntfsf_param_store uStore (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .wrEn      (dataTake),
    .wrIdx     (pIdx),
    .wrByte    (hostCyc.value),
    .loadEn    (lunInd.paramsReady),
    .loadBytes (lunInd.params),
    .rdIdx     (rdIdx),
    .rdByte    (storeByte),
    .allBytes  (storeAll)
  );

  // ****************************************
  // host read data path
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hostRd <= '0;
      rdIdx  <= '0;
    end else begin
      hostRd.rdValid <= rdStatusReq || idleRead;
      if (rdStatusReq || (idleRead && statusOut)) begin
        hostRd.isStatus <= 1'b1;
        hostRd.value    <= lunInd.status;
      end else if (idleRead) begin
        hostRd.isStatus <= 1'b0;
        hostRd.value    <= storeByte;
      end
      if (gfStart) begin
        rdIdx <= '0;
      end else if (idleRead && !statusOut) begin
        rdIdx <= rdIdx + 1'b1;
      end
    end
  end

  // ****************************************
  // AHB-Lite register slave
  // ****************************************
  wire addrPh = hsel && htrans[1] && hready;
  wire ctrlWr = wrPend && wrOff == ntfsf_pkg::REG_CTRL;

  // zero wait states, so ready and response are constant flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPend    <= 1'b0;
      wrOff     <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend    <= addrPh && hwrite && hsize == ntfsf_pkg::HSIZE_WORD;
      wrOff     <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // control register; a get-feature clear beats a software write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      selLun    <= ntfsf_pkg::LUN_RST;
      enhReq    <= 1'b0;
      chgCol    <= 1'b0;
      chgColEnh <= 1'b0;
    end else begin
      if (ctrlWr) begin
        selLun <= hwdata[ntfsf_pkg::CTRL_LUN_LSB +: ntfsf_pkg::LUN_W];
        enhReq <= hwdata[ntfsf_pkg::CTRL_ENH_BIT];
      end
      if (gfStart) begin
        chgCol    <= 1'b0;
        chgColEnh <= 1'b0;
      end else if (ctrlWr) begin
        chgCol    <= hwdata[ntfsf_pkg::CTRL_CHG_BIT];
        chgColEnh <= hwdata[ntfsf_pkg::CTRL_CHGE_BIT];
      end
    end
  end

  // read mux, sampled in the address phase; unmapped reads zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (haddr[7:0])
      ntfsf_pkg::REG_CTRL: begin
        rdMux[ntfsf_pkg::CTRL_LUN_LSB +: ntfsf_pkg::LUN_W] = selLun;
        rdMux[ntfsf_pkg::CTRL_ENH_BIT]  = enhReq;
        rdMux[ntfsf_pkg::CTRL_CHG_BIT]  = chgCol;
        rdMux[ntfsf_pkg::CTRL_CHGE_BIT] = chgColEnh;
      end
      ntfsf_pkg::REG_STATUS: begin
        rdMux[ntfsf_pkg::ST_READY_BIT]  = targetReady;
        rdMux[ntfsf_pkg::ST_SOUT_BIT]   = statusOut;
        rdMux[ntfsf_pkg::ST_SR6_BIT]    = lunReadyBit;
        rdMux[ntfsf_pkg::ST_ACTIVE_BIT] = !inIdle;
        rdMux[ntfsf_pkg::ST_LAST_LSB +: 8]  = lastCmd;
        rdMux[ntfsf_pkg::ST_FADDR_LSB +: 8] = featAddr;
      end
      ntfsf_pkg::REG_PARAMS: rdMux = storeAll;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPh && !hwrite) begin
      hrdata <= rdMux;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence seqSfStarted;
    state == S_SF_EXEC && lastCmd == ntfsf_pkg::CMD_SET_FEAT && lunReq.invalidateAll ##1 !lunReq.invalidateAll;
  endsequence
  sequence seqSfUpdated;
    state == S_SF_UPDATE && targetReady && lunReq.srBitSet
      ##1 (statusOut ? state == S_IDLE_RD : state == S_IDLE);
  endsequence
  sequence seqGfReady;
    state == S_GF_READY && targetReady && lunReq.srBitSet ##1 state == S_IDLE_RD;
  endsequence

  chk_sf_start_rec: assert property (sfStart |=> seqSfStarted)
    else $error("set-feature start not recorded");
  chk_feat_addr_store: assert property (addrTake |=> featAddr == $past(hostCyc.value)
    ##1 (state == S_SF_WAIT || state == S_GF_RETR))
    else $error("feature address not stored or no advance");
  chk_param_more: assert property (state == S_SF_STORE && pIdx != ntfsf_pkg::LAST_PIDX
    |=> state == S_SF_WAIT)
    else $error("parameter wait skipped");
  chk_param_last: assert property (state == S_SF_STORE && pIdx == ntfsf_pkg::LAST_PIDX
    |=> state == S_SF_COMPLETE)
    else $error("parameter count wrong");
  chk_sf_apply_act: assert property (sfApply |=> !targetReady && lunReq.srBitClear
    && lunReq.featureApply && resume == S_SF_COMPLETE && state == S_SF_COMPLETE)
    else $error("set-feature apply actions missing");
  chk_busy_rs_entry: assert property (busyRs |=> state == S_RS_EXEC)
    else $error("status command ignored while busy");
  chk_status_read: assert property (rdStatusReq |=> hostRd.rdValid && hostRd.isStatus)
    else $error("read while busy did not return status");
  chk_sf_finish: assert property (sfFinish |=> seqSfUpdated)
    else $error("set-feature finish wrong");
  chk_gf_start: assert property (gfStart |=> lastCmd == ntfsf_pkg::CMD_GET_FEAT
    && !chgCol && !chgColEnh && lunReq.invalidateAll && state == S_GF_EXEC)
    else $error("get-feature start wrong");
  chk_gf_fetch: assert property (gfFetch |=> !targetReady && lunReq.srBitClear
    && lunReq.featureRetrieve && resume == S_GF_RETR)
    else $error("get-feature fetch wrong");
  chk_gf_ready: assert property (gfReadyGo |=> seqGfReady)
    else $error("get-feature ready wrong");
  chk_rs_enh_block: assert property (state == S_RS_EXEC && enhReq |=> state != S_RS_PERFORM)
    else $error("status ran under enhanced flag");
  chk_rs_perform: assert property (state == S_RS_PERFORM |-> statusOut && lunReq.status70h
    ##1 state == (($past(resume) == S_IDLE) ? S_IDLE_RD : $past(resume)))
    else $error("status perform wrong");

endmodule : ntfsf_target_fsm

/* verilog/ntfsf_pkg.sv */
// Functional notes
// - set-feature: record EFh, invalidate all, await address
// - store feature address, then advance unconditionally
// - store parameter bytes until all have arrived
// - all stored: clear bit, go busy, apply
// - 70h while busy starts status; reads return status
// - set done: set bit, ready, idle or idle-read
// - get-feature: record EEh, invalidate, clear column flags
// - after address: clear bit, busy, fetch parameters
// - parameters ready: set bit, ready, idle-read
// - status: flag on, notify LUN, resume
package ntfsf_pkg;

  // ****************************************
  // sizes and command codes
  // ****************************************
  localparam int NUM_PARAMS = 4;
  localparam int PIDX_W     = 2;
  localparam int PAR_W      = 8 * NUM_PARAMS;
  localparam int LUN_W      = 2;
  localparam logic [PIDX_W-1:0] LAST_PIDX = PIDX_W'(NUM_PARAMS - 1);
  localparam logic [7:0] CMD_SET_FEAT    = 8'hEF;
  localparam logic [7:0] CMD_GET_FEAT    = 8'hEE;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_PARAMS  = 8'h08;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;
  localparam int CTRL_LUN_LSB  = 0;
  localparam int CTRL_ENH_BIT  = 2;
  localparam int CTRL_CHG_BIT  = 3;
  localparam int CTRL_CHGE_BIT = 4;
  localparam int ST_READY_BIT  = 0;
  localparam int ST_SOUT_BIT   = 1;
  localparam int ST_SR6_BIT    = 2;
  localparam int ST_ACTIVE_BIT = 3;
  localparam int ST_LAST_LSB   = 8;
  localparam int ST_FADDR_LSB  = 16;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]       LAST_CMD_RST = 8'h00;
  localparam logic [7:0]       FADDR_RST    = 8'h00;
  localparam logic [LUN_W-1:0] LUN_RST      = 2'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       cmd;     // command cycle
    logic       addr;    // address cycle
    logic       dataWr;  // data byte written
    logic       rdReq;   // read request
    logic [7:0] value;   // cycle byte
  } ntfsf_host_cyc_t;

  typedef struct packed {
    logic       rdValid;
    logic       isStatus;
    logic [7:0] value;
  } ntfsf_host_rd_t;

  typedef struct packed {
    logic             invalidateAll;
    logic             srBitClear;
    logic             srBitSet;
    logic             status70h;
    logic             featureApply;
    logic             featureRetrieve;
    logic [LUN_W-1:0] lun;
    logic [7:0]       featAddr;
    logic [PAR_W-1:0] params;
  } ntfsf_lun_req_t;

  typedef struct packed {
    logic             done;         // set-feature applied
    logic             paramsReady;  // get-feature data valid
    logic [7:0]       status;       // selected LUN status
    logic [PAR_W-1:0] params;
  } ntfsf_lun_ind_t;

endpackage : ntfsf_pkg

/* verilog/ntfsf_param_store.sv */
`timescale 1ns/10ps
module ntfsf_param_store (
  input  wire logic                         clk_sys,    // system clock
  input  wire logic                         resetn,     // async reset, low
  input  wire logic                         wrEn,       // write one byte
  input  wire logic [ntfsf_pkg::PIDX_W-1:0] wrIdx,      // byte index
  input  wire logic [7:0]                   wrByte,     // byte to write
  input  wire logic                         loadEn,     // load all bytes
  input  wire logic [ntfsf_pkg::PAR_W-1:0]  loadBytes,  // bytes to load
  input  wire logic [ntfsf_pkg::PIDX_W-1:0] rdIdx,      // read index
  output logic      [7:0]                   rdByte,     // indexed byte
  output logic      [ntfsf_pkg::PAR_W-1:0]  allBytes    // packed bytes
);

  logic [7:0] mem [ntfsf_pkg::NUM_PARAMS];

  // ****************************************
  // one byte register per parameter
  // ****************************************
  for (genvar g = 0; g < ntfsf_pkg::NUM_PARAMS; g++) begin : gEntry
    localparam logic [ntfsf_pkg::PIDX_W-1:0] IDX = ntfsf_pkg::PIDX_W'(g);
    // bulk load wins: the LUN answer replaces a stale host byte
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        mem[g] <= 8'h00;
      end else if (loadEn) begin
        mem[g] <= loadBytes[g*8 +: 8];
      end else if (wrEn && wrIdx == IDX) begin
        mem[g] <= wrByte;
      end
    end
    assign allBytes[g*8 +: 8] = mem[g];
  end

  // indexed read for the host data path
  assign rdByte = mem[rdIdx];

endmodule : ntfsf_param_store

/* test/ntfsf_lun_model.sv */
`timescale 1ns/10ps
// ****************************************
// behavioural LUN: answers feature requests late
// ****************************************
module ntfsf_lun_model #(
  parameter int              DLY = 30,            // cycles before an answer
  parameter logic [31:0]     PAR = 32'hD4C3B2A1   // retrieved parameters
) (
  input  wire logic          clk_sys,  // system clock
  input  wire logic          resetn,   // async reset, low
  input  ntfsf_pkg::ntfsf_lun_req_t lunReq,  // target requests
  output ntfsf_pkg::ntfsf_lun_ind_t lunInd   // answers to target
);
  int   cnt;
  logic isGet;
  logic sr6;
  // slow answer, so a status command fits inside the busy window
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt    <= 0;
      isGet  <= 1'b0;
      sr6    <= 1'b1;
      lunInd <= '0;
    end else begin
      lunInd.done        <= 1'b0;
      lunInd.paramsReady <= 1'b0;
      lunInd.params      <= ~lunInd.params;  // not valid: never holds still
      lunInd.status      <= {1'b1, sr6, 6'h00};
      if (lunReq.srBitClear) sr6 <= 1'b0;
      if (lunReq.srBitSet) sr6 <= 1'b1;
      if (lunReq.featureApply || lunReq.featureRetrieve) begin
        cnt   <= DLY;
        isGet <= lunReq.featureRetrieve;
      end else if (cnt == 1) begin
        cnt                <= 0;
        lunInd.done        <= !isGet;
        lunInd.paramsReady <= isGet;
        if (isGet) lunInd.params <= PAR;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : ntfsf_lun_model

/* test/nand_target_feature_status_fsm_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module nand_target_feature_status_fsm_tb;
  // ****************************************
  // clock, reset, design and partner
  // ****************************************
  logic                      clk_sys, resetn, hsel, hwrite, hreadyout, hresp, targetReady;
  logic [31:0]               haddr, hwdata, hrdata, d;
  logic [1:0]                htrans;
  logic [2:0]                hsize;
  ntfsf_pkg::ntfsf_host_cyc_t hostCyc;
  ntfsf_pkg::ntfsf_host_rd_t  hostRd;
  ntfsf_pkg::ntfsf_lun_ind_t  lunInd;
  ntfsf_pkg::ntfsf_lun_req_t  lunReq;
  int                        fails, tests_run, pc[6];
  wire logic [5:0]           pv = {lunReq.featureRetrieve, lunReq.featureApply, lunReq.status70h,
                                   lunReq.srBitSet, lunReq.srBitClear, lunReq.invalidateAll};
  ntfsf_target_fsm ntfsf_target_fsm_i (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hostCyc(hostCyc), .hostRd(hostRd), .targetReady(targetReady),
    .lunInd(lunInd), .lunReq(lunReq));
  ntfsf_lun_model ntfsf_lun_model_i (.clk_sys(clk_sys), .resetn(resetn), .lunReq(lunReq), .lunInd(lunInd));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // request pulses are counted so a short pulse is never missed
  always @(posedge clk_sys) for (int k = 0; k < 6; k++) pc[k] += pv[k];
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic waitRdy();
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin
      fails++;
      complete_run();
    end
  endtask : waitRdy
  // one single word transfer, read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsize  <= ntfsf_pkg::HSIZE_WORD;
    waitRdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp);
  endtask : ahb
  // one host cycle: k = {cmd, addr, dataWr, rdReq}, strobes 2 cycles apart
  task automatic hc(input logic [3:0] k, input logic [7:0] v);
    @(posedge clk_sys);
    hostCyc <= {k, v};
    @(posedge clk_sys);
    hostCyc <= '0;
  endtask : hc
  task automatic hostRead(input logic st, input logic [7:0] v);
    hc(4'h1, 8'h00);
    @(negedge clk_sys);
    `CHK("rdValid", 1'b1, hostRd.rdValid);
    `CHK("isStatus", st, hostRd.isStatus);
    `CHK("rdValue", v, hostRd.value);
  endtask : hostRead
  task automatic waitPc(input int k, input int n);
    int i;
    for (i = 0; i < 200 && pc[k] < n; i++) @(negedge clk_sys);
    `CHK("pulseCount", n, pc[k]);
    if (i >= 200) complete_run();
  endtask : waitPc
  // one more edge after ready rises, so the set-bit pulse is counted and the LUN model has set sr6
  task automatic waitReady();
    int i;
    for (i = 0; i < 200 && targetReady !== 1'b1; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    `CHK("ready", 1'b1, targetReady);
    if (i >= 200) complete_run();
  endtask : waitReady
  // ****************************************
  // scenarios
  // ****************************************
  task automatic setFeature();
    ahb(1'b1, ntfsf_pkg::REG_CTRL, 32'h00000002, d);
    hc(4'h8, ntfsf_pkg::CMD_SET_FEAT);
    waitPc(0, 1);
    ahb(1'b0, ntfsf_pkg::REG_STATUS, 32'h0, d);
    `CHK("lastCmd", 8'hEF, d[15:8]);
    hc(4'h4, 8'h5A);
    for (int i = 0; i < 4; i++) hc(4'h2, 8'(8'h11 * (i + 1)));
    waitPc(4, 1);
    `CHK("busy", 1'b0, targetReady);
    `CHK("srClear", 1, pc[1]);
    `CHK("lun", 2'h2, lunReq.lun);
    `CHK("featAddr", 8'h5A, lunReq.featAddr);
    `CHK("params", 32'h44332211, lunReq.params);
    hc(4'h8, ntfsf_pkg::CMD_READ_STATUS);
    waitPc(3, 1);
    hostRead(1'b1, 8'h80);
    waitReady();
    `CHK("srSet", 1, pc[2]);
    hostRead(1'b1, 8'hC0);
  endtask : setFeature
  task automatic getFeature();
    ahb(1'b1, ntfsf_pkg::REG_CTRL, 32'h00000019, d);
    hc(4'h8, ntfsf_pkg::CMD_GET_FEAT);
    waitPc(0, 2);
    ahb(1'b0, ntfsf_pkg::REG_CTRL, 32'h0, d);
    `CHK("chgFlags", 2'h0, d[4:3]);
    ahb(1'b0, ntfsf_pkg::REG_STATUS, 32'h0, d);
    `CHK("lastCmd", 8'hEE, d[15:8]);
    hc(4'h4, 8'h3C);
    waitPc(5, 1);
    `CHK("busy", 1'b0, targetReady);
    `CHK("srClear", 2, pc[1]);
    `CHK("featAddr", 8'h3C, lunReq.featAddr);
    waitReady();
    `CHK("srSet", 2, pc[2]);
    for (int i = 0; i < 5; i++) hostRead(1'b0, 8'(8'hA1 + 8'h11 * (i % 4)));
    ahb(1'b0, ntfsf_pkg::REG_PARAMS, 32'h0, d);
    `CHK("paramsReg", 32'hD4C3B2A1, d);
    ahb(1'b0, 8'h40, 32'h0, d);
    `CHK("unmapped", 32'h0, d);
  endtask : getFeature
  task automatic plainStatus();
    ahb(1'b1, ntfsf_pkg::REG_CTRL, 32'h00000004, d);
    hc(4'h8, ntfsf_pkg::CMD_READ_STATUS);
    repeat (6) @(negedge clk_sys);
    `CHK("enhDrop", 1, pc[3]);
    ahb(1'b1, ntfsf_pkg::REG_CTRL, 32'h0, d);
    hc(4'h8, ntfsf_pkg::CMD_READ_STATUS);
    waitPc(3, 2);
    hostRead(1'b1, 8'hC0);
  endtask : plainStatus
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {resetn, hsel, hwrite, haddr, hwdata, htrans, hsize, fails, tests_run} = '0;
    hostCyc = '0;
    pc = '{default: 0};
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    setFeature();
    getFeature();
    plainStatus();
    complete_run();
  end
endmodule : nand_target_feature_status_fsm_tb
